// ===== dlc_pkg.sv
// Package with offsets, command codes, counts and types of the layout command decoder
package dlc_pkg;

  // Width of the register index and of the parameter counter
  localparam int IDX_W = 5;
  localparam int CNT_W = 4;
  localparam int REG_NUM = 32;

  // Register offsets of the stored settings
  localparam logic [4:0] REG_SYS_BASE = 5'h00;
  localparam logic [4:0] REG_CHAR_HEIGHT = 5'h02;
  localparam logic [4:0] REG_BYTES_PER_LINE = 5'h03;
  localparam logic [4:0] REG_TOTAL_LINE_SPAN = 5'h04;
  localparam logic [4:0] REG_LINES_PER_FRAME = 5'h05;
  localparam logic [4:0] REG_VWIDTH_LOW = 5'h06;
  localparam logic [4:0] REG_VWIDTH_HIGH = 5'h07;
  localparam logic [4:0] REG_BLK1_START_LOW = 5'h0B;
  localparam logic [4:0] REG_BLK1_START_HIGH = 5'h0C;
  localparam logic [4:0] REG_BLK1_LINES = 5'h0D;
  localparam logic [4:0] REG_BLK2_START_LOW = 5'h0E;
  localparam logic [4:0] REG_BLK2_START_HIGH = 5'h0F;
  localparam logic [4:0] REG_BLK2_LINES = 5'h10;
  localparam logic [4:0] REG_BLK3_START_LOW = 5'h11;
  localparam logic [4:0] REG_BLK3_START_HIGH = 5'h12;
  localparam logic [4:0] REG_BLK4_START_LOW = 5'h13;
  localparam logic [4:0] REG_BLK4_START_HIGH = 5'h14;
  localparam logic [4:0] REG_LAYER_COMBINE = 5'h18;
  localparam logic [4:0] REG_PIXEL_SHIFT = 5'h1B;

  // Command codes handled here
  localparam logic [7:0] CMD_SYSTEM_SET = 8'h40;
  localparam logic [7:0] CMD_SCROLL = 8'h44;
  localparam logic [7:0] CMD_FINE_HSCROLL = 8'h5A;
  localparam logic [7:0] CMD_OVERLAY = 8'h5B;

  // Parameter counts per command
  localparam logic [3:0] SYS_PARAMS = 4'h8;
  localparam logic [3:0] SCROLL_PARAMS = 4'hA;
  localparam logic [3:0] SINGLE_PARAM = 4'h1;

  // Field masks for narrow registers
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_CHAR_HEIGHT = 8'h0F;
  localparam logic [7:0] MASK_PIXEL_SHIFT = 8'h07;
  localparam logic [7:0] MASK_LAYER = 8'h0F;

  // Values after reset
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic SYNC_IDLE = 1'b1;

  // Decoder states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_PARAM = 2'b10
  } dlc_state_type;

  // First register written by a command
  function automatic logic [4:0] cmdBase(input logic [7:0] cmd);
    case (cmd)
      CMD_SYSTEM_SET: cmdBase = REG_SYS_BASE;
      CMD_SCROLL: cmdBase = REG_BLK1_START_LOW;
      CMD_FINE_HSCROLL: cmdBase = REG_PIXEL_SHIFT;
      CMD_OVERLAY: cmdBase = REG_LAYER_COMBINE;
      default: cmdBase = REG_SYS_BASE;
    endcase
  endfunction

  // Number of parameters a command takes, zero when unknown
  function automatic logic [3:0] cmdCount(input logic [7:0] cmd);
    case (cmd)
      CMD_SYSTEM_SET: cmdCount = SYS_PARAMS;
      CMD_SCROLL: cmdCount = SCROLL_PARAMS;
      CMD_FINE_HSCROLL: cmdCount = SINGLE_PARAM;
      CMD_OVERLAY: cmdCount = SINGLE_PARAM;
      default: cmdCount = CNT_RESET;
    endcase
  endfunction

  // Bits that a register keeps
  function automatic logic [7:0] regMask(input logic [4:0] idx);
    case (idx)
      REG_CHAR_HEIGHT: regMask = MASK_CHAR_HEIGHT;
      REG_PIXEL_SHIFT: regMask = MASK_PIXEL_SHIFT;
      REG_LAYER_COMBINE: regMask = MASK_LAYER;
      default: regMask = MASK_FULL;
    endcase
  endfunction

endpackage

// ===== dlc_pin_sync.sv
// Two-stage synchroniser for host pins
`timescale 1ns/1ps
module dlc_pin_sync #(
  parameter int WIDTH = 10,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic [WIDTH-1:0] pinIn, // Raw pin levels
  output logic [WIDTH-1:0] pinOut // Synchronised levels
);

  logic [WIDTH-1:0] stage1_r; // First stage, read only by second

  // Two flip-flops per pin
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stage1_r <= IDLE;
      pinOut <= IDLE;
    end
    else
    begin
      stage1_r <= pinIn;
      pinOut <= stage1_r;
    end
  end

endmodule

// ===== dlc_param_router.sv
// Maps command and parameter position to a register index
`timescale 1ns/1ps
module dlc_param_router (
  input wire logic [7:0] activeCmd, // Latest command code
  input wire logic [3:0] paramIdx, // Position of next parameter
  output logic [4:0] regIdx, // Target register index
  output logic regHit, // Parameter lands in a stored register
  output logic cmdKnown, // Command takes parameters here
  output logic lastParam // This parameter is the last one
);
  import dlc_pkg::*;

  logic [3:0] paramTotal; // Parameters of this command
  logic sysHead; // First two setup bytes, not held here

  assign paramTotal = cmdCount(activeCmd);
  assign cmdKnown = (paramTotal != CNT_RESET);
  // Parameters go to consecutive registers in order
  assign regIdx = cmdBase(activeCmd) + {1'b0, paramIdx};
  assign sysHead = (activeCmd == CMD_SYSTEM_SET) && (regIdx < REG_CHAR_HEIGHT);
  assign regHit = cmdKnown && (paramIdx < paramTotal) && !sysHead;
  assign lastParam = (paramIdx == paramTotal - SINGLE_PARAM);

endmodule

// ===== dlc_decoder.sv
// Command and parameter decoder holding display layout settings
// Summary of operation
// - Setup parameter 3 sets char height, bits 3-0
// - Setup parameter 4 sets bytes per line
// - Setup parameter 5 sets total line span
// - Setup parameter 6 sets lines per frame
// - Setup parameters 7, 8 form virtual width
// - Scroll parameters 1, 2 give block 1 start
// - Scroll parameter 3 gives block 1 lines
// - Scroll parameters 4, 5 give block 2 start
// - Scroll parameter 6 gives block 2 lines
// - Scroll parameters 7, 8 give block 3 start
// - Scroll parameters 9, 10 give block 4 start
// - Fine scroll parameter sets pixel shift bits 2-0
// - Overlay bits 1-0 choose layer combining
// - Overlay bit 2 selects block 1 mode
// - Overlay bit 3 selects block 3 mode
// - Count fields hold the count minus one
`timescale 1ns/1ps
module dlc_decoder (
  input wire logic clk, // System clock, 100 MHz
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic hostWrN, // Host write strobe pin, active low
  input wire logic commandParameterSelect, // High for command, low for parameter
  input wire logic [7:0] hostData, // Host data pins
  output logic [3:0] charHeightField, // Character height minus one
  output logic [7:0] bytesPerLine, // Bytes per line minus one
  output logic [7:0] totalLineSpanField, // Total addresses per line
  output logic [7:0] linesPerFrame, // Lines per frame minus one
  output logic [15:0] virtualWidthField, // Virtual screen width
  output logic [15:0] block1Start, // First block start address
  output logic [7:0] block1LineCount, // First block line count
  output logic [15:0] block2Start, // Second block start address
  output logic [7:0] block2LineCount, // Second block line count
  output logic [15:0] block3Start, // Third block start address
  output logic [15:0] block4Start, // Fourth block start address
  output logic [1:0] layerCombineMethod, // Layer combining method
  output logic block1TextSelect, // First block graphics when high
  output logic block3TextSelect, // Third block graphics when high
  output logic [2:0] pixelShift, // Fine horizontal shift
  output logic [7:0] activeCmd, // Latest command code
  output logic [3:0] paramCount, // Parameters taken since command
  output logic paramBusy // Decoder expects more parameters
);
  import dlc_pkg::*;

  localparam int SYNC_W = 10;
  localparam logic [SYNC_W-1:0] SYNC_RESET = {SYNC_IDLE, 9'h000};

  logic [SYNC_W-1:0] syncBus; // Synchronised pins
  logic wrNSync; // Synchronised strobe
  logic selSync; // Synchronised select
  logic [7:0] dataSync; // Synchronised data
  logic wrNPrev_r; // Strobe one cycle earlier
  logic wrDone; // Strobe just released
  logic cmdPulse; // Command byte taken
  logic parPulse; // Parameter byte taken
  logic [7:0] regFile [0:REG_NUM-1]; // Settings store
  logic [7:0] activeCmd_r; // Latest command
  logic [7:0] activeCmd_nxt; // Next command
  logic [3:0] paramIdx_r; // Parameter position
  logic [3:0] paramIdx_nxt; // Next position
  dlc_state_type state_r; // Decoder state
  dlc_state_type state_nxt; // Next state
  logic [4:0] regIdx; // Target register
  logic regHit; // Target is stored
  logic cmdKnown; // Command known here
  logic lastParam; // Last parameter of command
  logic cmdKnownNew; // Incoming command is known
  logic regWrite; // Store a parameter now
  logic [7:0] regWrData; // Masked parameter

  // Host pins cross into the system clock
  dlc_pin_sync #(
    .WIDTH(SYNC_W),
    .IDLE(SYNC_RESET)
  ) u_dlc_pin_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinIn({hostWrN, commandParameterSelect, hostData}),
    .pinOut(syncBus)
  );

  assign wrNSync = syncBus[9];
  assign selSync = syncBus[8];
  assign dataSync = syncBus[7:0];

  // Previous strobe level for edge detection
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      wrNPrev_r <= SYNC_IDLE;
    else
      wrNPrev_r <= wrNSync;
  end

  // A write is taken when the strobe rises again
  assign wrDone = wrNSync && !wrNPrev_r;
  assign cmdPulse = wrDone && selSync;
  assign parPulse = wrDone && !selSync;

  // Parameter position to register mapping
  dlc_param_router u_dlc_param_router (
    .activeCmd(activeCmd_r),
    .paramIdx(paramIdx_r),
    .regIdx(regIdx),
    .regHit(regHit),
    .cmdKnown(cmdKnown),
    .lastParam(lastParam)
  );

  assign cmdKnownNew = (cmdCount(dataSync) != CNT_RESET);
  assign regWrite = parPulse && (state_r == ST_PARAM) && regHit;
  // narrow fields keep only their bits
  assign regWrData = dataSync & regMask(regIdx);

  // Next state, command and parameter position
  always_comb
  begin
    state_nxt = state_r;
    activeCmd_nxt = activeCmd_r;
    paramIdx_nxt = paramIdx_r;
    case (state_r)
      ST_IDLE:
      begin
        // Only a command leaves idle
        if (cmdPulse)
        begin
          activeCmd_nxt = dataSync;
          paramIdx_nxt = CNT_RESET;
          state_nxt = cmdKnownNew ? ST_PARAM : ST_IDLE;
        end
      end
      ST_PARAM:
      begin
        if (cmdPulse)
        begin
          activeCmd_nxt = dataSync;
          paramIdx_nxt = CNT_RESET;
          state_nxt = cmdKnownNew ? ST_PARAM : ST_IDLE;
        end
        else if (parPulse)
        begin
          paramIdx_nxt = paramIdx_r + SINGLE_PARAM;
          state_nxt = lastParam ? ST_IDLE : ST_PARAM;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Decoder state registers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= ST_IDLE;
      activeCmd_r <= CMD_RESET;
      paramIdx_r <= CNT_RESET;
    end
    else
    begin
      state_r <= state_nxt;
      activeCmd_r <= activeCmd_nxt;
      paramIdx_r <= paramIdx_nxt;
    end
  end

  // Settings store, one parameter per write
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < REG_NUM; i++)
        regFile[i] <= REG_RESET;
    end
    else if (regWrite)
      regFile[regIdx] <= regWrData;
  end

  assign charHeightField = regFile[REG_CHAR_HEIGHT][3:0];
  // counts kept as written, minus one
  // bytes per line, count minus one
  assign bytesPerLine = regFile[REG_BYTES_PER_LINE];
  assign totalLineSpanField = regFile[REG_TOTAL_LINE_SPAN];
  // lines per frame, count minus one
  assign linesPerFrame = regFile[REG_LINES_PER_FRAME];
  assign virtualWidthField = {regFile[REG_VWIDTH_HIGH], regFile[REG_VWIDTH_LOW]};
  assign block1Start = {regFile[REG_BLK1_START_HIGH], regFile[REG_BLK1_START_LOW]};
  assign block1LineCount = regFile[REG_BLK1_LINES];
  assign block2Start = {regFile[REG_BLK2_START_HIGH], regFile[REG_BLK2_START_LOW]};
  assign block2LineCount = regFile[REG_BLK2_LINES];
  assign block3Start = {regFile[REG_BLK3_START_HIGH], regFile[REG_BLK3_START_LOW]};
  assign block4Start = {regFile[REG_BLK4_START_HIGH], regFile[REG_BLK4_START_LOW]};
  assign layerCombineMethod = regFile[REG_LAYER_COMBINE][1:0];
  assign block1TextSelect = regFile[REG_LAYER_COMBINE][2];
  assign block3TextSelect = regFile[REG_LAYER_COMBINE][3];
  assign pixelShift = regFile[REG_PIXEL_SHIFT][2:0];

  // Decoder status
  assign activeCmd = activeCmd_r;
  assign paramCount = paramIdx_r;
  assign paramBusy = (state_r == ST_PARAM);

  // Checks on the stored settings
  logic parSys; // Setup parameter taken
  logic parScroll; // Scroll parameter taken
  logic parSingle; // First parameter of any command taken
  assign parSys = parPulse && paramBusy && (activeCmd_r == CMD_SYSTEM_SET);
  assign parScroll = parPulse && paramBusy && (activeCmd_r == CMD_SCROLL);
  assign parSingle = parPulse && paramBusy && (paramIdx_r == CNT_RESET);

  char_height_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      parSys && (paramIdx_r == 4'h2) |=> charHeightField == $past(dataSync[3:0]))
    else $error("character height not stored");

  bytes_line_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      parSys && (paramIdx_r == 4'h3) |=> bytesPerLine == $past(dataSync))
    else $error("bytes per line not stored");

  line_span_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      parSys && (paramIdx_r == 4'h4) |=> totalLineSpanField == $past(dataSync))
    else $error("line span not stored");

  frame_lines_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      parSys && (paramIdx_r == 4'h5) |=> linesPerFrame == $past(dataSync))
    else $error("lines per frame not stored");

  virtual_width_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      parSys && (paramIdx_r == 4'h7) |=> virtualWidthField[15:8] == $past(dataSync))
    else $error("virtual width high byte not stored");

  block1_start_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      parScroll && (paramIdx_r == 4'h0) |=> block1Start[7:0] == $past(dataSync))
    else $error("block 1 start low byte not stored");

  block1_lines_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      parScroll && (paramIdx_r == 4'h2) |=> block1LineCount == $past(dataSync))
    else $error("block 1 line count not stored");

  block2_start_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      parScroll && (paramIdx_r == 4'h4) |=> block2Start[15:8] == $past(dataSync))
    else $error("block 2 start high byte not stored");

  block2_lines_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      parScroll && (paramIdx_r == 4'h5) |=> block2LineCount == $past(dataSync))
    else $error("block 2 line count not stored");

  block3_start_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      parScroll && (paramIdx_r == 4'h6) |=> block3Start[7:0] == $past(dataSync))
    else $error("block 3 start low byte not stored");

  block4_start_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      parScroll && (paramIdx_r == 4'h9) |=> block4Start[15:8] == $past(dataSync)
        ##1 !paramBusy)
    else $error("block 4 start high byte not stored");

  pixel_shift_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      parSingle && (activeCmd_r == CMD_FINE_HSCROLL)
        |=> pixelShift == $past(dataSync[2:0]) && !paramBusy)
    else $error("pixel shift not stored");

  overlay_mode_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      parSingle && (activeCmd_r == CMD_OVERLAY)
        |=> {block3TextSelect, block1TextSelect, layerCombineMethod}
          == $past(dataSync[3:0]))
    else $error("overlay setting not stored");

  cmd_restart_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      cmdPulse |=> activeCmd == $past(dataSync) && paramCount == CNT_RESET)
    else $error("command does not restart routing");

  idle_hold_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      !paramBusy && !cmdPulse |=> $stable(block1Start) && $stable(pixelShift))
    else $error("setting changed with no parameter expected");

  width_low_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      parSys && (paramIdx_r == 4'h6) |=> virtualWidthField[7:0] == $past(dataSync))
    else $error("virtual width low byte not stored");

  block1_high_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      parScroll && (paramIdx_r == 4'h1) |=> block1Start[15:8] == $past(dataSync))
    else $error("block 1 start high byte not stored");

  block2_low_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      parScroll && (paramIdx_r == 4'h3) |=> block2Start[7:0] == $past(dataSync))
    else $error("block 2 start low byte not stored");

  block3_high_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      parScroll && (paramIdx_r == 4'h7) |=> block3Start[15:8] == $past(dataSync))
    else $error("block 3 start high byte not stored");

  block4_low_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      parScroll && (paramIdx_r == 4'h8) |=> block4Start[7:0] == $past(dataSync))
    else $error("block 4 start low byte not stored");

  block1_mode_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      parSingle && (activeCmd_r == CMD_OVERLAY) |=> block1TextSelect == $past(dataSync[2]))
    else $error("block 1 mode bit not stored");

  block3_mode_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      parSingle && (activeCmd_r == CMD_OVERLAY) |=> block3TextSelect == $past(dataSync[3]))
    else $error("block 3 mode bit not stored");

  busy_known_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      paramBusy |-> cmdKnown)
    else $error("parameters expected for an unknown command");

  last_param_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      parPulse && paramBusy && lastParam |=> !paramBusy)
    else $error("still busy after the last parameter");

endmodule

// ===== dlc_host_model.sv
// Host processor model writing command and parameter bytes
`timescale 1ns/1ps
module dlc_host_model (
  input wire logic clk, // System clock
  output logic hostWrN, // Write strobe, active low
  output logic commandParameterSelect, // High for command byte
  output logic [7:0] hostData // Data byte
);
  // Idle bus from time zero
  initial
  begin
    hostWrN = 1'b1;
    commandParameterSelect = 1'b0;
    hostData = 8'h00;
  end

  // One write: select and data stand three clocks before the strobe release
  task automatic writeByte(input logic sel, input logic [7:0] data);
    @(posedge clk);
    // select high for command, low for parameter
    commandParameterSelect <= sel;
    hostData <= data;
    hostWrN <= 1'b0;
    repeat (3) @(posedge clk);
    hostWrN <= 1'b1;
    repeat (2) @(posedge clk);
    // Hold time over, so the lines stop showing the old byte
    hostData <= ~data;
    commandParameterSelect <= ~sel;
    repeat (3) @(posedge clk);
  endtask
endmodule

// ===== tb.sv
// Self-checking testbench for the layout command decoder
`timescale 1ns/1ps
module tb;
  import dlc_pkg::*;
  logic clk; // System clock
  logic sys_rst; // Reset, active high
  logic hostWrN; // Write strobe from host model
  logic commandParameterSelect; // Command or parameter
  logic [7:0] hostData; // Host data byte
  logic [3:0] charHeightField; // Settings seen at the ports
  logic [7:0] bytesPerLine, totalLineSpanField, linesPerFrame, block1LineCount;
  logic [15:0] virtualWidthField, block1Start, block2Start, block3Start, block4Start;
  logic [7:0] block2LineCount, activeCmd;
  logic [1:0] layerCombineMethod;
  logic block1TextSelect, block3TextSelect, paramBusy;
  logic [2:0] pixelShift;
  logic [3:0] paramCount;
  logic [7:0] refReg [32]; // Expected register image
  logic [7:0] refCmd; // Expected latest command
  logic [3:0] refCnt; // Expected parameters taken
  int errTotal; // Mismatches
  int checkCount; // Comparisons
  int cycles; // Timeout counter
  int seedVal; // Seed result
  logic [7:0] cmdTab [5] = '{CMD_SYSTEM_SET, CMD_SCROLL, CMD_FINE_HSCROLL, CMD_OVERLAY, 8'h42};
  logic [7:0] exVals [18] = '{8'h38, 8'h87, 8'h07, 8'h3F, 8'h49, 8'h7F, 8'h80, 8'h00,
    8'h00, 8'h00, 8'h40, 8'h00, 8'h10, 8'h40, 8'h00, 8'h04, 8'h00, 8'h30};

  dlc_host_model u_dlc_host_model (.clk(clk), .hostWrN(hostWrN),
    .commandParameterSelect(commandParameterSelect), .hostData(hostData));

  dlc_decoder u_dlc_decoder (.clk(clk), .sys_rst(sys_rst), .hostWrN(hostWrN),
    .commandParameterSelect(commandParameterSelect), .hostData(hostData),
    .charHeightField(charHeightField), .bytesPerLine(bytesPerLine),
    .totalLineSpanField(totalLineSpanField), .linesPerFrame(linesPerFrame),
    .virtualWidthField(virtualWidthField), .block1Start(block1Start),
    .block1LineCount(block1LineCount), .block2Start(block2Start),
    .block2LineCount(block2LineCount), .block3Start(block3Start), .block4Start(block4Start),
    .layerCombineMethod(layerCombineMethod), .block1TextSelect(block1TextSelect),
    .block3TextSelect(block3TextSelect), .pixelShift(pixelShift), .activeCmd(activeCmd),
    .paramCount(paramCount), .paramBusy(paramBusy));

  // Clock at 100 MHz
  always #5 clk = ~clk;

  // Parameter count of a command, zero when not handled here
  function automatic logic [3:0] refLimit(input logic [7:0] cmd);
    refLimit = (cmd == CMD_SYSTEM_SET) ? 4'h8 : (cmd == CMD_SCROLL) ? 4'hA :
      (cmd == CMD_FINE_HSCROLL || cmd == CMD_OVERLAY) ? 4'h1 : 4'h0;
  endfunction

  // First register a command fills
  function automatic logic [4:0] refBase(input logic [7:0] cmd);
    refBase = (cmd == CMD_SCROLL) ? 5'h0B : (cmd == CMD_FINE_HSCROLL) ? 5'h1B :
      (cmd == CMD_OVERLAY) ? 5'h18 : 5'h00;
  endfunction

  // Clear the expected image as reset does
  task automatic refReset();
    foreach (refReg[i]) refReg[i] = 8'h00;
    refCmd = 8'h00;
    refCnt = 4'h0;
  endtask

  // Write one byte and follow it in the expected image
  task automatic send(input logic sel, input logic [7:0] d);
    logic [4:0] idx;
    u_dlc_host_model.writeByte(sel, d);
    idx = refBase(refCmd) + 5'(refCnt);
    if (sel)
    begin
      refCmd = d;
      refCnt = 4'h0;
    end
    else if (refCnt < refLimit(refCmd))
    begin
      // Setup parameters 1 and 2 are counted but kept elsewhere
      if (!(refCmd == CMD_SYSTEM_SET && refCnt < 4'h2))
        refReg[idx] = d;
      refCnt = refCnt + 4'h1;
    end
  endtask

  // Compare one value
  task automatic checkVal(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Compare every port against the expected image
  task automatic checkAll();
    #1;
    checkVal("charHeight", 16'(charHeightField), 16'(refReg[2][3:0]));
    checkVal("bytesPerLine", 16'(bytesPerLine), 16'(refReg[3]));
    checkVal("lineSpan", 16'(totalLineSpanField), 16'(refReg[4]));
    checkVal("linesFrame", 16'(linesPerFrame), 16'(refReg[5]));
    checkVal("vWidth", virtualWidthField, {refReg[7], refReg[6]});
    checkVal("blk1Start", block1Start, {refReg[12], refReg[11]});
    checkVal("blk1Lines", 16'(block1LineCount), 16'(refReg[13]));
    checkVal("blk2Start", block2Start, {refReg[15], refReg[14]});
    checkVal("blk2Lines", 16'(block2LineCount), 16'(refReg[16]));
    checkVal("blk3Start", block3Start, {refReg[18], refReg[17]});
    checkVal("blk4Start", block4Start, {refReg[20], refReg[19]});
    checkVal("pixShift", 16'(pixelShift), 16'(refReg[27][2:0]));
    checkVal("combine", 16'(layerCombineMethod), 16'(refReg[24][1:0]));
    checkVal("blk1Text", 16'(block1TextSelect), 16'(refReg[24][2]));
    checkVal("blk3Text", 16'(block3TextSelect), 16'(refReg[24][3]));
    checkVal("activeCmd", 16'(activeCmd), 16'(refCmd));
    checkVal("paramCount", 16'(paramCount), 16'(refCnt));
    checkVal("busy", 16'(paramBusy), 16'(refCnt < refLimit(refCmd)));
  endtask

  // Print counts and verdict, then stop
  task automatic finalReport();
    $display("Comparisons %0d, mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Cut a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errTotal++;
      finalReport();
    end
  end

  // Main sequence
  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    errTotal = 0;
    checkCount = 0;
    cycles = 0;
    refReset();
    seedVal = $urandom(32'h78ae);
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    checkAll();
    $display("Test reset done");
    // example setup and scroll values, counts written minus one
    send(1'b1, CMD_SYSTEM_SET);
    for (int i = 0; i < 8; i++) send(1'b0, exVals[i]);
    send(1'b1, CMD_SCROLL);
    for (int i = 8; i < 18; i++) send(1'b0, exVals[i]);
    send(1'b0, 8'hEE);
    checkAll();
    $display("Test example done");
    // Every overlay pattern and fine shift, upper bits random, extra byte ignored
    for (int v = 0; v < 16; v++)
    begin
      send(1'b1, CMD_OVERLAY);
      send(1'b0, {4'($urandom), 4'(v)});
      send(1'b1, CMD_FINE_HSCROLL);
      send(1'b0, {5'($urandom), 3'(v)});
      send(1'b0, 8'hFF);
      checkAll();
    end
    $display("Test modes done");
    // Random commands cut short or overrun
    for (int k = 0; k < 30; k++)
    begin
      send(1'b1, cmdTab[$urandom % 5]);
      for (int p = $urandom % 12; p > 0; p--) send(1'b0, 8'($urandom));
      checkAll();
    end
    $display("Test random done");
    // Reset in mid-run
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    refReset();
    checkAll();
    // decoder takes commands again after reset
    send(1'b1, CMD_OVERLAY);
    send(1'b0, 8'h01);
    checkAll();
    $display("Test second reset done");
    finalReport();
  end
endmodule
